// ### logic/output_on_off_and_fault_clear.v
// Function
// R1 - top three config bits dropped, read zero
// R2 - always_on_select low means on with power
// R3 - bus_command_enable gates the bus request
// R4 - pin_response_enable low ignores enable pin
// R5 - pin mode needs power, pin, bus term
// R6 - pin_sense_level picks enable pin polarity
// R7 - new polarity takes effect after restart
// R8 - pin_off_action reads zero, writes dropped
// R9 - fault clear routed by page selection
// R10 - fault clear wipes selected status at once
// R11 - fault clear releases the alert output once no status bit is left
// R12 - fault clear never restarts latched channel
// R13 - persisting fault sets its bit again
// R14 - fault clear is command code only
// R15 - two-bit page code, 10 ignored
// R16 - enable pin passes two-flop synchroniser
`include "onoff_consts.vh"

module output_on_off_and_fault_clear #(
   parameter NCH = 2
) (
   input  wire             clk,              // system clock, 100 MHz
   input  wire             rst,              // synchronous reset, high
   input  wire             cmd_valid,        // one-cycle command strobe
   input  wire             cmd_write,        // 1 write, 0 read
   input  wire             cmd_has_data,     // a data byte came along
   input  wire [7:0]       cmd_code,         // command code
   input  wire [7:0]       cmd_data,         // data byte of a write
   output reg              rsp_valid,        // one-cycle answer strobe
   output reg  [7:0]       rsp_data,         // read data
   output reg              rsp_error,        // command refused
   input  wire [NCH-1:0]   enable_pin,       // raw enable pins
   input  wire [NCH-1:0]   supply_low_flag,  // input undervoltage
   input  wire [NCH-1:0]   nv_sense_level,   // stored pin polarity
   input  wire [8*NCH-1:0] fault_active,     // fault conditions, level
   input  wire [NCH-1:0]   fault_latch,      // latch-off fault pulse
   output wire [NCH-1:0]   output_enable,    // channel output enables
   output wire [NCH-1:0]   latched_off,      // channel latched off
   output wire [1:0]       page_sel,         // current page code
   output wire             alert_n_o,        // alert pin drive level
   output wire             alert_n_oe        // alert pin pulled low
);

   // page, alert and per-channel word buses
   reg  [1:0]       page_q;
   reg              alert_q;
   wire [1:0]       page_d;
   wire [NCH-1:0]   pin_sync;
   wire [NCH-1:0]   sel;
   wire [NCH-1:0]   clr;
   wire [8*NCH-1:0] status_d_all;
   wire [8*NCH-1:0] status_all;
   wire [8*NCH-1:0] cfg_rd_all;
   wire [8*NCH-1:0] op_rd_all;
   wire             wr_ok;
   wire             is_clear;
   wire             clear_ok;
   wire             rd_ch;
   wire             known;
   reg  [7:0]       rd_mux;
   reg              err_d;

   // command decode, refusal terms and paged read words
   wire             is_page;
   wire             is_oper;
   wire             is_cfg;
   wire             is_stat;
   wire             page_bad;
   wire             any_status;
   wire             ref_clear;
   wire             ref_write;
   wire             ref_read;
   wire             rd_ok;
   wire [7:0]       rd_op;
   wire [7:0]       rd_cfg;
   wire [7:0]       rd_stat;

   // enable pins are asynchronous to clk
   sync2 #(
      .W (NCH)
   ) u_pin_sync (
      .clk (clk),
      .rst (rst),
      .d   (enable_pin),
      .q   (pin_sync)    // R16
   );

   // command decode; the flags feed the refusal terms and the
   // register writes, while the read mux compares the code again
   assign is_page  = cmd_code == `CMD_PAGE;
   assign is_oper  = cmd_code == `CMD_OPERATION;
   assign is_cfg   = cmd_code == `CMD_ON_OFF_CFG;
   assign is_stat  = cmd_code == `CMD_STATUS_WORD;
   assign is_clear = cmd_code == `CMD_CLEAR_FAULTS;
   assign known    = is_page | is_oper | is_cfg | is_stat | is_clear;

   // command qualification
   assign wr_ok    = cmd_valid & cmd_write & cmd_has_data;
   assign clear_ok = cmd_valid & cmd_write & ~cmd_has_data & is_clear; // R14

   // page selection register; the illegal code leaves it unchanged
   assign page_d   = {cmd_data[`PAGE_BIT_HI], cmd_data[`PAGE_BIT_LO]};
   assign page_bad = page_d == `PAGE_ILLEGAL;
   always @(posedge clk) begin
      if (rst) begin
         page_q <= `PAGE_RST;
      end else if (wr_ok && is_page && !page_bad) begin
         page_q <= page_d; // R15
      end
   end
   assign page_sel = page_q;

   // channel targets; reads with both selected look at the first page
   assign sel[0] = (page_q == `PAGE_FIRST) | (page_q == `PAGE_BOTH); // R9
   assign sel[1] = (page_q == `PAGE_SECOND) | (page_q == `PAGE_BOTH); // R9
   assign rd_ch  = page_q == `PAGE_SECOND;
   assign clr    = sel & {NCH{clear_ok}}; // R9

   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : ch
         // per-channel registers and their next state
         reg        always_on_q;
         reg        bus_en_q;
         reg        pin_en_q;
         reg        sense_reg_q;
         reg        sense_eff_q;
         reg        on_q;
         reg  [3:0] margin_q;
         reg  [7:0] status_q;
         wire [7:0] status_d;
         wire       wr_here;
         wire       cfg_wr;
         wire       op_wr;

         assign wr_here = wr_ok & sel[g];
         assign cfg_wr  = wr_here & is_cfg;
         assign op_wr   = wr_here & is_oper;

         // turn-on source configuration; bits 7:5 and 0 are not stored
         always @(posedge clk) begin
            if (rst) begin
               always_on_q <= `CFG_ALWAYS_ON_RST;
               bus_en_q    <= `CFG_BUS_EN_RST;
               pin_en_q    <= `CFG_PIN_EN_RST;
               sense_reg_q <= nv_sense_level[g];
            end else if (cfg_wr) begin
               always_on_q <= cmd_data[`CFG_ALWAYS_ON_BIT]; // R1 R8
               bus_en_q    <= cmd_data[`CFG_BUS_EN_BIT];
               pin_en_q    <= cmd_data[`CFG_PIN_EN_BIT];
               sense_reg_q <= cmd_data[`CFG_SENSE_BIT];
            end
         end

         // polarity in use is only reloaded by a restart, so a live
         // write cannot flip the channel on or off by surprise
         always @(posedge clk) begin
            if (rst) begin
               sense_eff_q <= nv_sense_level[g]; // R7
            end
         end

         // operation register: bus request and stored margin code
         always @(posedge clk) begin
            if (rst) begin
               on_q     <= `OP_ON_RST;
               margin_q <= `OP_MARGIN_RST;
            end else if (op_wr) begin
               on_q     <= cmd_data[`OP_ON_BIT];
               margin_q <= cmd_data[`OP_MARGIN_HI:`OP_MARGIN_LO];
            end
         end

         // status: a fault still present wins over the clear
         assign status_d = (status_q & ~{8{clr[g]}}) |
                           fault_active[8*g+7:8*g]; // R10 R13
         always @(posedge clk) begin
            if (rst) begin
               status_q <= `STATUS_RST;
            end else begin
               status_q <= status_d; // R10
            end
         end

         // words gathered for the read path and the alert; the next
         // status goes out so the alert lands with the clear
         assign status_d_all[8*g+7:8*g] = status_d;
         assign status_all[8*g+7:8*g]   = status_q;
         assign cfg_rd_all[8*g+7:8*g]   = {3'h0, always_on_q, bus_en_q,
                                           pin_en_q, sense_reg_q,
                                           1'b0}; // R1 R8
         assign op_rd_all[8*g+7:8*g]    = {on_q, 1'b0, margin_q, 2'h0};

         on_decision u_dec (
            .clk         (clk),
            .rst         (rst),
            .always_on_n (always_on_q),
            .bus_en      (bus_en_q),
            .pin_en      (pin_en_q),
            .sense_level (sense_eff_q),
            .pin_sync    (pin_sync[g]),
            .bus_req     (on_q),
            .supply_low  (supply_low_flag[g]),
            .latch_fault (fault_latch[g]),
            .enable_q    (output_enable[g]),
            .latched_q   (latched_off[g])
         );
      end
   endgenerate

   // any bit left set once this cycle's clear is applied
   assign any_status = |status_d_all; // R13

   // alert follows the status contents; released in the clear cycle
   // unless an unselected channel keeps a bit or a fault still present sets its bit again
   always @(posedge clk) begin
      if (rst) begin
         alert_q <= 1'b0;
      end else begin
         alert_q <= any_status; // R11 R13
      end
   end
   assign alert_n_o  = 1'b0;
   assign alert_n_oe = alert_q;

   // word of the paged channel; with both pages the first one answers
   assign rd_op   = rd_ch ? op_rd_all[15:8] : op_rd_all[7:0];
   assign rd_cfg  = rd_ch ? cfg_rd_all[15:8] : cfg_rd_all[7:0]; // R1
   assign rd_stat = rd_ch ? status_all[15:8] : status_all[7:0];

   // read data selection
   always @* begin
      case (cmd_code)
         `CMD_PAGE: begin
            rd_mux = {page_q[1], 6'h00, page_q[0]};
         end
         `CMD_OPERATION: begin
            rd_mux = rd_op;
         end
         `CMD_ON_OFF_CFG: begin
            rd_mux = rd_cfg; // R1 R8
         end
         `CMD_STATUS_WORD: begin
            rd_mux = rd_stat;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // refusal terms: a clear must come bare, a write needs its data
   // byte, status is read-only and page code 10 is illegal
   assign ref_clear = ~cmd_write | cmd_has_data; // R14
   assign ref_write = ~cmd_has_data | is_stat | (is_page & page_bad); // R15
   assign ref_read  = cmd_has_data;

   // refused commands change no register and return no data
   always @* begin
      if (!known) begin
         err_d = 1'b1;
      end else if (is_clear) begin
         err_d = ref_clear;
      end else if (cmd_write) begin
         err_d = ref_write;
      end else begin
         err_d = ref_read;
      end
   end

   // only an accepted read loads a word into the answer
   assign rd_ok = cmd_valid & ~cmd_write & ~err_d;

   // one answer strobe per command, the cycle after it
   always @(posedge clk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp_error <= 1'b0;
      end else begin
         rsp_valid <= cmd_valid;
         rsp_error <= cmd_valid & err_d;
      end
   end

   // zero outside accepted reads, so a stale word never rides along
   // with a later answer
   always @(posedge clk) begin
      if (rst) begin
         rsp_data <= 8'h00;
      end else if (rd_ok) begin
         rsp_data <= rd_mux;
      end else begin
         rsp_data <= 8'h00;
      end
   end

endmodule

// ### logic/onoff_consts.vh
`ifndef ONOFF_CONSTS_VH
`define ONOFF_CONSTS_VH

// command codes seen on the command port
`define CMD_PAGE          8'h00
`define CMD_OPERATION     8'h01
`define CMD_ON_OFF_CFG    8'h02
`define CMD_CLEAR_FAULTS  8'h03
`define CMD_STATUS_WORD   8'h79

// page selection codes, taken from data bits 7 and 0
`define PAGE_FIRST        2'b00
`define PAGE_SECOND       2'b01
`define PAGE_ILLEGAL      2'b10
`define PAGE_BOTH         2'b11
`define PAGE_BIT_HI       7
`define PAGE_BIT_LO       0
`define PAGE_RST          2'b00

// turn-on source configuration fields
`define CFG_ALWAYS_ON_BIT 4
`define CFG_BUS_EN_BIT    3
`define CFG_PIN_EN_BIT    2
`define CFG_SENSE_BIT     1
`define CFG_OFF_ACT_BIT   0
`define CFG_ALWAYS_ON_RST 1'b1
`define CFG_BUS_EN_RST    1'b0
`define CFG_PIN_EN_RST    1'b1

// operation register fields
`define OP_ON_BIT         7
`define OP_MARGIN_HI      5
`define OP_MARGIN_LO      2
`define OP_ON_RST         1'b0
`define OP_MARGIN_RST     4'h0

// status register reset
`define STATUS_RST        8'h00

`endif

// ### logic/sync2.v
module sync2 #(
   parameter W = 2
) (
   input  wire         clk,   // system clock
   input  wire         rst,   // synchronous reset, active high
   input  wire [W-1:0] d,     // asynchronous inputs
   output wire [W-1:0] q      // synchronised outputs
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   // two flops; the first is read only by the second
   always @(posedge clk) begin
      if (rst) begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;

endmodule

// ### logic/on_decision.v
module on_decision (
   input  wire clk,          // system clock
   input  wire rst,          // synchronous reset, active high
   input  wire always_on_n,  // always_on_select bit (0 = always on)
   input  wire bus_en,       // bus_command_enable bit
   input  wire pin_en,       // pin_response_enable bit
   input  wire sense_level,  // polarity in force since last reset
   input  wire pin_sync,     // synchronised enable_pin
   input  wire bus_req,      // bus_turn_request (operation on bit)
   input  wire supply_low,   // supply_low_flag
   input  wire latch_fault,  // fault that latches the channel off
   output reg  enable_q,     // channel output enable
   output reg  latched_q     // channel latched off by fault
);

   reg pin_act;
   reg request;

   // turn-on decision from the source configuration
   always @* begin
      pin_act = sense_level ? pin_sync : ~pin_sync; // R6 R16
      if (!always_on_n) begin
         request = ~supply_low; // R2
      end else if (!pin_en) begin
         request = ~supply_low & bus_en & bus_req; // R4 R3
      end else begin
         request = ~supply_low & pin_act & (~bus_en | bus_req); // R5 R3
      end
   end

   // latch holds until the request itself drops; a status clear never
   // reaches here, so the channel stays off after faults are cleared
   always @(posedge clk) begin
      if (rst) begin
         latched_q <= 1'b0;
         enable_q  <= 1'b0;
      end else begin
         if (latch_fault) begin
            latched_q <= 1'b1; // R12
         end else if (!request) begin
            latched_q <= 1'b0;
         end
         enable_q <= request & ~latched_q & ~latch_fault; // R12
      end
   end

endmodule

// ### verification/pmbus_host_model.sv
module pmbus_host_model (
   input  wire        clk,           // system clock
   output logic       cmd_valid,     // command strobe
   output logic       cmd_write,     // write or send-byte
   output logic       cmd_has_data,  // data byte present
   output logic [7:0] cmd_code,      // command code
   output logic [7:0] cmd_data,      // data byte
   input  wire        rsp_valid,     // answer strobe
   input  wire  [7:0] rsp_data,      // read data
   input  wire        rsp_error      // refused
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_has_data = 1'b0;
      cmd_code = 8'hFF;
      cmd_data = 8'h00;
   end
   // one command, answer sampled in the cycle after the taking edge
   task automatic send(input logic w, h, input logic [7:0] c, d,
                       output logic [7:0] rd, output logic ok, er);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_has_data = h;
      cmd_code = c;
      cmd_data = d;
      @(negedge clk);
      ok = rsp_valid;
      rd = rsp_data;
      er = rsp_error;
      cmd_valid = 1'b0;
      // released lines show junk, never the last value
      cmd_code = ~c;
      cmd_data = ~d;
   endtask
endmodule

// ### verification/onoff_assertions.sv
`include "onoff_consts.vh"
module onoff_checker #(
   parameter NCH = 2
) (
   input wire             clk,             // clock
   input wire             rst,             // reset
   input wire             cmd_valid,       // strobe
   input wire             cmd_write,       // write
   input wire             cmd_has_data,    // data present
   input wire [7:0]       cmd_code,        // code
   input wire [7:0]       cmd_data,        // data
   input wire             rsp_valid,       // answer
   input wire [7:0]       rsp_data,        // read data
   input wire             rsp_error,       // refused
   input wire [NCH-1:0]   enable_pin,      // pins
   input wire [NCH-1:0]   supply_low_flag, // undervoltage
   input wire [NCH-1:0]   nv_sense_level,  // stored polarity
   input wire [8*NCH-1:0] fault_active,    // faults
   input wire [NCH-1:0]   fault_latch,     // latch-off faults
   input wire [NCH-1:0]   output_enable,   // enables
   input wire [NCH-1:0]   latched_off,     // latched
   input wire [1:0]       page_sel,        // page
   input wire             alert_n_o,       // alert level
   input wire             alert_n_oe       // alert drive
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // command shapes seen at the port
   sequence s_clear;
      cmd_valid && cmd_write && !cmd_has_data &&
         cmd_code == `CMD_CLEAR_FAULTS;
   endsequence
   sequence s_page_wr;
      cmd_valid && cmd_write && cmd_has_data && cmd_code == `CMD_PAGE;
   endsequence
   sequence s_cfg_rd;
      cmd_valid && !cmd_write && !cmd_has_data &&
         cmd_code == `CMD_ON_OFF_CFG;
   endsequence
   a_clear_taken: assert property (
      s_clear |=> rsp_valid && !rsp_error) else $error("clear refused");
   a_clear_data_refused: assert property (
      cmd_valid && cmd_write && cmd_has_data &&
      cmd_code == `CMD_CLEAR_FAULTS |=> rsp_error)
      else $error("clear with data taken");
   a_cfg_top_zero: assert property (
      s_cfg_rd |=> rsp_valid && rsp_data[7:5] == 3'h0)
      else $error("config top bits not zero");
   a_off_action_zero: assert property (
      s_cfg_rd |=> rsp_data[0] == 1'b0) else $error("off action not 0");
   a_page_illegal: assert property (
      s_page_wr ##0 (cmd_data[7] && !cmd_data[0])
      |=> rsp_error && $stable(page_sel)) else $error("page 10 taken");
   a_page_legal: assert property (
      s_page_wr ##0 !(cmd_data[7] && !cmd_data[0])
      |=> page_sel == {$past(cmd_data[7]), $past(cmd_data[0])})
      else $error("page not taken");
   a_latch_blocks: assert property (
      fault_latch[0] |=> !output_enable[0] && latched_off[0])
      else $error("latch fault did not stop channel");
   a_fault_alert: assert property (
      fault_active != 16'h0000 |=> alert_n_oe) else $error("no alert");
   a_clear_release: assert property (
      s_clear ##0 (page_sel == `PAGE_BOTH && fault_active == 16'h0000)
      |=> !alert_n_oe) else $error("alert not released");
   a_alert_level: assert property (
      alert_n_o == 1'b0) else $error("alert level not low");
endmodule

// ### verification/output_on_off_and_fault_clear_bench.sv
`include "onoff_consts.vh"
module output_on_off_and_fault_clear_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   wire         cv, cw, ch, rv, re, aout, aoe;
   wire  [7:0]  cc, cd, rdat;
   wire  [1:0]  oe, lat, pg;
   logic [1:0]  pin = 2'b00, low = 2'b00, nvs = 2'b11, flat = 2'b00;
   logic [15:0] fact = 16'h0000;
   logic [7:0]  rd;
   logic        ok, er;
   int          num_errors = 0, samples_checked = 0;
   always #5 clk = ~clk;
   pmbus_host_model host (.clk(clk), .cmd_valid(cv), .cmd_write(cw),
      .cmd_has_data(ch), .cmd_code(cc), .cmd_data(cd), .rsp_valid(rv),
      .rsp_data(rdat), .rsp_error(re));
   output_on_off_and_fault_clear #(.NCH(2)) dut (.clk(clk), .rst(rst),
      .cmd_valid(cv), .cmd_write(cw), .cmd_has_data(ch), .cmd_code(cc),
      .cmd_data(cd), .rsp_valid(rv), .rsp_data(rdat), .rsp_error(re),
      .enable_pin(pin), .supply_low_flag(low), .nv_sense_level(nvs),
      .fault_active(fact), .fault_latch(flat), .output_enable(oe),
      .latched_off(lat), .page_sel(pg), .alert_n_o(aout),
      .alert_n_oe(aoe));
   task chk(input string nm, input logic [7:0] e, g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task cmd(input logic w, h, input logic [7:0] c, d);
      host.send(w, h, c, d, rd, ok, er);
      chk("rsp_valid", 8'h01, {7'h00, ok});
   endtask
   task do_reset;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
   endtask
   task finish_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task t_config;
      cmd(0, 0, `CMD_ON_OFF_CFG, 8'h00);
      chk("cfg reset", 8'h16, rd);
      cmd(1, 1, `CMD_ON_OFF_CFG, 8'hE1);
      cmd(0, 0, `CMD_ON_OFF_CFG, 8'h00);
      chk("cfg dropped", 8'h00, rd);
      $display("t_config done");
   endtask
   task t_decision;
      logic [7:0] cf[10] = '{8'h00, 8'h00, 8'h10, 8'h18, 8'h16, 8'h16,
                             8'h16, 8'h1E, 8'h1E, 8'h14};
      logic [7:0] op[10] = '{8'h00, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h80, 8'h00};
      logic [9:0] pn = 10'b1101110100, lw = 10'b0001000010;
      logic [9:0] ex = 10'b1100111001;
      for (int i = 0; i < 10; i++) begin
         cmd(1, 1, `CMD_ON_OFF_CFG, cf[i]);
         cmd(1, 1, `CMD_OPERATION, op[i]);
         @(negedge clk) pin = {1'b0, pn[i]};
         low = {1'b0, lw[i]};
         repeat (4) @(negedge clk);
         chk("output_enable", {7'h00, ex[i]}, {7'h00, oe[0]});
      end
      nvs = 2'b00;
      do_reset;
      cmd(0, 0, `CMD_ON_OFF_CFG, 8'h00);
      chk("cfg after restart", 8'h14, rd);
      @(negedge clk) pin = 2'b01;
      repeat (4) @(negedge clk);
      chk("active low pin", 8'h00, {7'h00, oe[0]});
      @(negedge clk) pin = 2'b00;
      repeat (4) @(negedge clk);
      chk("active low on", 8'h01, {7'h00, oe[0]});
      nvs = 2'b11;
      do_reset;
      cmd(1, 1, `CMD_PAGE, 8'h81);
      cmd(1, 1, `CMD_ON_OFF_CFG, 8'h00);
      repeat (2) @(negedge clk);
      chk("both pages on", 8'h03, {6'h00, oe});
      low = 2'b10;
      repeat (2) @(negedge clk);
      chk("second low", 8'h01, {6'h00, oe});
      $display("t_decision done");
   endtask
   task t_clear;
      logic [7:0] pd[3] = '{8'h00, 8'h01, 8'h81};
      for (int p = 0; p < 3; p++) begin
         @(negedge clk) fact = 16'h0101;
         @(negedge clk) fact = 16'h0000;
         cmd(1, 1, `CMD_PAGE, pd[p]);
         cmd(1, 0, `CMD_CLEAR_FAULTS, 8'h00);
         chk("alert", (p == 2) ? 8'h00 : 8'h01, {7'h00, aoe});
         for (int c = 0; c < 2; c++) begin
            cmd(1, 1, `CMD_PAGE, c[7:0]);
            cmd(0, 0, `CMD_STATUS_WORD, 8'h00);
            chk("status", (p == 2 || p == c) ? 8'h00 : 8'h01, rd);
         end
      end
      @(negedge clk) fact = 16'h0001;
      cmd(1, 1, `CMD_PAGE, 8'h81);
      cmd(1, 0, `CMD_CLEAR_FAULTS, 8'h00);
      chk("alert kept", 8'h01, {7'h00, aoe});
      cmd(1, 1, `CMD_PAGE, 8'h00);
      cmd(0, 0, `CMD_STATUS_WORD, 8'h00);
      chk("status kept", 8'h01, rd);
      fact = 16'h0000;
      $display("t_clear done");
   endtask
   task t_refused;
      cmd(1, 1, `CMD_PAGE, 8'h01);
      cmd(1, 1, `CMD_PAGE, 8'h80);
      chk("page 10 error", 8'h01, {7'h00, er});
      chk("page kept", 8'h01, {6'h00, pg});
      cmd(1, 1, `CMD_CLEAR_FAULTS, 8'h00);
      chk("clear data error", 8'h01, {7'h00, er});
      cmd(0, 0, `CMD_CLEAR_FAULTS, 8'h00);
      chk("clear read error", 8'h01, {7'h00, er});
      $display("t_refused done");
   endtask
   task t_latch;
      cmd(1, 1, `CMD_PAGE, 8'h00);
      cmd(1, 1, `CMD_ON_OFF_CFG, 8'h00);
      @(negedge clk) low = 2'b00;
      repeat (4) @(negedge clk);
      chk("on before latch", 8'h01, {7'h00, oe[0]});
      flat = 2'b01;
      @(negedge clk) flat = 2'b00;
      cmd(1, 0, `CMD_CLEAR_FAULTS, 8'h00);
      repeat (4) @(negedge clk);
      chk("latched", 8'h01, {7'h00, lat[0]});
      chk("stays off", 8'h00, {7'h00, oe[0]});
      $display("t_latch done");
   endtask
   // watchdog cuts a hang short
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      finish_test();
   end
   // main sequence
   initial begin
      do_reset;
      t_config;
      t_decision;
      t_clear;
      t_refused;
      t_latch;
      finish_test();
   end
endmodule
bind output_on_off_and_fault_clear onoff_checker #(.NCH(NCH)) u_chk (
   .clk(clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
   .cmd_has_data(cmd_has_data), .cmd_code(cmd_code), .cmd_data(cmd_data),
   .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
   .enable_pin(enable_pin), .supply_low_flag(supply_low_flag),
   .nv_sense_level(nv_sense_level), .fault_active(fault_active),
   .fault_latch(fault_latch), .output_enable(output_enable),
   .latched_off(latched_off), .page_sel(page_sel),
   .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe));
